// [bench/pin_model.sv]
// partner model driving the trigger and capture pins
`timescale 1ns/1ps
`default_nettype none
module pin_model (
   // clock
   input  wire logic CLK,
   // pins
   output var  logic EXT_TRIGGER_PIN,
   output var  logic CAPTURE_PIN_0,
   output var  logic CAPTURE_PIN_1
);
   initial begin
      EXT_TRIGGER_PIN = 1'b0;
      CAPTURE_PIN_0 = 1'b0;
      CAPTURE_PIN_1 = 1'b0;
   end
   // level held four cycles so the edge detector sees it
   task automatic drive(input int n, input logic v);
      @(posedge CLK);
      case (n)
         0: CAPTURE_PIN_0 <= v;
         1: CAPTURE_PIN_1 <= v;
         default: EXT_TRIGGER_PIN <= v;
      endcase
      repeat (4) @(posedge CLK);
   endtask
endmodule
`default_nettype wire

// [bench/timer_pulse_capture_modes_tb_top.sv]
// testbench for the pulse/capture timer
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.vh"
module timer_pulse_capture_modes_tb_top;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, tout, trig, cp0, cp1, err;
   int          miscompares = 0, num_checks = 0;
   always #12.5 clk = ~clk;
   tmr_core DUT (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .COUNT_TICK(1'b1),
      .EXT_TRIGGER_PIN(trig), .CAPTURE_PIN_0(cp0), .CAPTURE_PIN_1(cp1),
      .TIMER_OUT(tout));
   pin_model PINS (.CLK(clk), .EXT_TRIGGER_PIN(trig), .CAPTURE_PIN_0(cp0),
      .CAPTURE_PIN_1(cp1));
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask
   task automatic chk_in(input string nm, input logic [31:0] lo, hi, g);
      num_checks++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         $display("ERROR %s expected %h..%h seen %h", nm, lo, hi, g);
         miscompares++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // request held until the edge that samples pready high
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         results();
      end
   endtask
   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic wait_out(input logic v);
      int n;
      n = 0;
      while (tout !== v && n < 200) begin
         @(negedge clk);
         n++;
      end
      chk("timer_out", v, tout);
      if (n >= 200) results();
   endtask
   task automatic t_reset;
      rdc("run", `OFS_RUN, 32'h0);
      rdc("ctrl", `OFS_CTRL, 32'h0);
      rdc("flags", `OFS_FLAGS, 32'h0);
      rdc("unmapped", 8'h40, 32'h0);
      chk("slverr", 1'b1, err);
      $display("test reset done");
   endtask
   task automatic t_pulse;
      apb(1'b1, `OFS_CTRL, 32'hB8);
      apb(1'b1, `OFS_CMPA, 32'h6);
      apb(1'b1, `OFS_PERIOD, 32'h2);
      apb(1'b1, `OFS_RUN, 32'h1);
      wait_out(1'b1);
      wait_out(1'b0);
      rdc("run", `OFS_RUN, 32'h0);
      rdc("flags", `OFS_FLAGS, 32'h1);
      apb(1'b0, `OFS_COUNT, 32'h0);
      chk_in("count", 32'h6, 32'h7, rd);
      apb(1'b1, `OFS_FLAGS, 32'h3);
      apb(1'b1, `OFS_CMPA, 32'h30);
      PINS.drive(2, 1'b1);
      wait_out(1'b1);
      PINS.drive(2, 1'b0);
      rdc("run", `OFS_RUN, 32'h1);
      apb(1'b1, `OFS_RUN, 32'h0);
      wait_out(1'b0);
      rdc("flags", `OFS_FLAGS, 32'h0);
      $display("test pulse done");
   endtask
   task automatic t_capture;
      logic        c;
      logic [31:0] c32;
      apb(1'b1, `OFS_PERIOD, 32'h0);
      apb(1'b1, `OFS_CTRL, 32'h4F);
      apb(1'b1, `OFS_RUN, 32'h1);
      for (int io = 0; io < 4; io++) begin
         apb(1'b1, `OFS_CTRL, 32'h4F | (io << 4));
         for (int v = 1; v >= 0; v--) begin
            apb(1'b1, `OFS_CMPA, 32'h0);
            apb(1'b1, `OFS_FLAGS, 32'h3);
            PINS.drive(io & 1, v[0]);
            c = io == 2 || (io < 2 && io[0] != v[0]);
            apb(1'b0, `OFS_CMPA, 32'h0);
            if (c) chk_in("capture", 32'h1, 32'hFFFF, rd);
            else chk("capture", 32'h0, rd);
            rdc("flag_a", `OFS_FLAGS, {31'h0, c});
         end
      end
      apb(1'b0, `OFS_COUNT, 32'h0);
      c32 = rd;
      chk("cap_out", 32'h0, tout);
      apb(1'b0, `OFS_COUNT, 32'h0);
      chk_in("count_run", c32 + 1, 32'hFFFF, rd);
      apb(1'b1, `OFS_RUN, 32'h0);
      apb(1'b1, `OFS_PERIOD, 32'h3);
      apb(1'b1, `OFS_FLAGS, 32'h3);
      apb(1'b1, `OFS_RUN, 32'h1);
      repeat (10) @(posedge clk);
      apb(1'b0, `OFS_COUNT, 32'h0);
      chk_in("count_wrap", 32'h0, 32'h3, rd);
      rdc("flag_p", `OFS_FLAGS, 32'h2);
      $display("test capture done");
   endtask
   task automatic t_pwm;
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `OFS_CTRL, 32'h80 | (i[0] << 4) | (i[1] << 2));
         repeat (3) @(negedge clk);
         chk("forced_out", i[0] ^ i[1], tout);
      end
      $display("test pwm done");
   endtask
   task automatic t_modes;
      int h;
      h = 0;
      apb(1'b1, `OFS_RUN, 32'h0);
      apb(1'b1, `OFS_CMPA, 32'h2);
      apb(1'b1, `OFS_PERIOD, 32'h4);
      apb(1'b1, `OFS_CTRL, 32'hA9);
      apb(1'b1, `OFS_RUN, 32'h1);
      repeat (10) @(negedge clk);
      for (int k = 0; k < 20; k++) begin
         @(negedge clk);
         if (tout === 1'b1) h++;
      end
      chk("pwm_high", 32'h8, h);
      apb(1'b1, `OFS_RUN, 32'h0);
      apb(1'b1, `OFS_CMPA, 32'h3);
      apb(1'b1, `OFS_PERIOD, 32'h7);
      apb(1'b1, `OFS_CTRL, 32'h30);
      apb(1'b1, `OFS_FLAGS, 32'h3);
      apb(1'b1, `OFS_RUN, 32'h1);
      wait_out(1'b0);
      wait_out(1'b1);
      wait_out(1'b0);
      rdc("cmp_flags", `OFS_FLAGS, 32'h3);
      wait_out(1'b1);
      apb(1'b1, `OFS_CTRL, 32'hF0);
      repeat (3) @(negedge clk);
      chk("timer_out", 32'h0, tout);
      $display("test modes done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_pulse();
      t_capture();
      t_pwm();
      t_modes();
      results();
   end
endmodule
`default_nettype wire

// [bench/tmr_chk_assertions.sv]
// port checker for the pulse/capture timer
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.vh"
module tmr_chk_assertions #(
   parameter CNT_W = 16
) (
   // clock and reset
   input wire logic        CLK,
   input wire logic        SYS_RST,
   // apb
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   // pins
   input wire logic        EXT_TRIGGER_PIN,
   input wire logic        TIMER_OUT
);
   logic [7:0] ctrl_q;
   logic [1:0] age_q;
   wire        wr = PSEL & PENABLE & PREADY & PWRITE;
   wire        run_wr = wr && PADDR == `OFS_RUN;
   wire        sp = ctrl_q == 8'hB8 && age_q == 2'h3;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // shadow of the control word, aged so only settled modes are judged
   always @(posedge CLK) begin
      if (SYS_RST) begin
         ctrl_q <= 8'h00;
         age_q <= 2'h0;
      end else if (wr && PADDR == `OFS_CTRL) begin
         ctrl_q <= PWDATA[7:0];
         age_q <= 2'h0;
      end else if (age_q != 2'h3) begin
         age_q <= age_q + 2'h1;
      end
   end
   a_ready_setup: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("pready missing after setup");
   a_ready_once: assert property (PREADY |-> $past(PSEL) && !$past(PENABLE))
      else $error("pready without setup");
   a_err_unmapped: assert property (PREADY && PADDR > 8'h14 |-> PSLVERR)
      else $error("no error on unmapped address");
   a_idle_rdata: assert property (!PSEL && !$past(PSEL) |-> PRDATA == 32'h0)
      else $error("read data not zero when idle");
   a_sp_start: assert property (
      sp && run_wr && PWDATA[0] && !TIMER_OUT |-> ##[1:4] TIMER_OUT)
      else $error("pulse did not start on run");
   a_sp_trigger: assert property (
      sp && $rose(EXT_TRIGGER_PIN) && !TIMER_OUT |-> ##[1:6] TIMER_OUT)
      else $error("pulse did not start on trigger");
   a_sp_stop: assert property (
      sp && run_wr && !PWDATA[0] && TIMER_OUT |-> ##[1:4] !TIMER_OUT)
      else $error("pulse did not end on run clear");
   a_pwm_forced: assert property (
      age_q == 2'h3 && ctrl_q[7:6] == 2'h2 && !ctrl_q[5]
      |-> TIMER_OUT == (ctrl_q[4] ^ ctrl_q[2]))
      else $error("forced pwm level wrong");
   a_cap_quiet: assert property (
      age_q == 2'h3 && ctrl_q[7:6] == 2'h1 |=> $stable(TIMER_OUT))
      else $error("output moved in capture mode");
endmodule
bind tmr_core tmr_chk_assertions #(.CNT_W(CNT_W)) chk (
   .CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_TRIGGER_PIN(EXT_TRIGGER_PIN),
   .TIMER_OUT(TIMER_OUT));
`default_nettype wire

// [core/tmr_core.v]
// standard timer: compare, pwm, single pulse and capture modes with apb
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.vh"

module tmr_core #(
   parameter CNT_W = 16
) (
   // clock and reset
   input  wire        CLK,
   input  wire        SYS_RST,
   // apb slave
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   // timer pins
   input  wire        COUNT_TICK,
   input  wire        EXT_TRIGGER_PIN,
   input  wire        CAPTURE_PIN_0,
   input  wire        CAPTURE_PIN_1,
   output reg         TIMER_OUT
);

   localparam [CNT_W-1:0] CNT_MAX  = {CNT_W{1'b1}};
   localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};

   // software visible state
   reg              run_control_q;
   reg              run_prev_q;
   reg [`CTL_W-1:0] timer_control_1_q;
   reg [CNT_W-1:0]  count_q;
   reg [CNT_W-1:0]  compare_a_value_q;
   reg [CNT_W-1:0]  period_value_q;
   reg              match_a_flag_q;
   reg              match_p_flag_q;
   // pin history for edge detection
   reg              trig_prev_q;
   reg              cap0_prev_q;
   reg              cap1_prev_q;
   reg              pwm_wave_q;

   wire [1:0] mode_select       = {timer_control_1_q[`CTL_M_HI],
                                   timer_control_1_q[`CTL_M_LO]};
   wire [1:0] pin_action_select = {timer_control_1_q[`CTL_IO_HI],
                                   timer_control_1_q[`CTL_IO_LO]};
   wire clear_select    = timer_control_1_q[`CTL_CLR_BIT];
   wire duty_swap       = timer_control_1_q[`CTL_DPX_BIT];
   wire polarity_invert = timer_control_1_q[`CTL_POL_BIT];
   wire initial_level   = timer_control_1_q[`CTL_OC_BIT];

   wire single_mode = (mode_select == `MODE_PWM) &&
                      (pin_action_select == `IO_3);
   wire pwm_mode    = (mode_select == `MODE_PWM) && !single_mode;
   wire cap_mode    = (mode_select == `MODE_CAP);
   wire cmp_like    = (mode_select == `MODE_CMP) ||
                      (mode_select == `MODE_TMR);

   // apb decode
   wire apb_wr = PSEL && PENABLE && PREADY && PWRITE;
   wire wr_run    = apb_wr && (PADDR == `OFS_RUN);
   wire wr_ctrl   = apb_wr && (PADDR == `OFS_CTRL);
   wire wr_cmpa   = apb_wr && (PADDR == `OFS_CMPA);
   wire wr_period = apb_wr && (PADDR == `OFS_PERIOD);
   wire wr_flags  = apb_wr && (PADDR == `OFS_FLAGS);

   // counter events
   wire run_rise  = run_control_q && !run_prev_q;
   wire counting  = run_control_q && !run_rise && COUNT_TICK;
   wire a_equal   = (count_q == compare_a_value_q);
   // a zero period lets the counter run to its top value
   wire p_top     = (period_value_q == CNT_ZERO);
   wire p_equal   = p_top ? (count_q == CNT_MAX)
                          : (count_q == period_value_q);
   // pwm: duty_swap exchanges the roles of the two compare values
   wire [CNT_W-1:0] pwm_period = duty_swap ? compare_a_value_q
                                           : period_value_q;
   wire [CNT_W-1:0] pwm_duty   = duty_swap ? period_value_q
                                           : compare_a_value_q;
   wire pwm_end = (pwm_period == CNT_ZERO) ? (count_q == CNT_MAX)
                                           : (count_q == pwm_period);

   wire a_hit = counting && a_equal && !cap_mode;
   wire p_hit = counting && p_equal && !single_mode;

   // capture edge selection
   wire rise0 = CAPTURE_PIN_0 && !cap0_prev_q;
   wire fall0 = !CAPTURE_PIN_0 && cap0_prev_q;
   wire rise1 = CAPTURE_PIN_1 && !cap1_prev_q;
   wire fall1 = !CAPTURE_PIN_1 && cap1_prev_q;
   reg  cap_edge;
   always @* begin
      case (pin_action_select)
         `IO_0:   cap_edge = rise0 || rise1;
         `IO_1:   cap_edge = fall0 || fall1;
         `IO_2:   cap_edge = rise0 || rise1 || fall0 || fall1;
         `IO_3:   cap_edge = 1'b0;
         default: cap_edge = 1'b0;
      endcase
   end
   // pin direction is not consulted, so driven edges capture too
   wire capture = cap_mode && run_control_q && cap_edge;

   wire trig_edge = EXT_TRIGGER_PIN && !trig_prev_q;

   // counter clear conditions per mode
   reg clear_cnt;
   always @* begin
      clear_cnt = 1'b0;
      if (cmp_like) begin
         clear_cnt = clear_select ? (counting && a_equal) : p_hit;
      end else if (pwm_mode) begin
         clear_cnt = counting && pwm_end;
      end else if (cap_mode) begin
         clear_cnt = p_hit;
      end
   end

   // run_control: software write, hardware clear, trigger set
   reg run_d;
   always @* begin
      run_d = run_control_q;
      if (wr_run) begin
         run_d = PWDATA[0];
      end
      if (single_mode && a_hit) begin
         run_d = 1'b0;
      end
      if (single_mode && trig_edge) begin
         run_d = 1'b1;
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         run_control_q <= `RST_RUN;
         run_prev_q    <= `RST_RUN;
      end else begin
         run_control_q <= run_d;
         run_prev_q    <= run_control_q;
      end
   end

   // counter
   always @(posedge CLK) begin
      if (SYS_RST) begin
         count_q <= CNT_ZERO;
      end else if (run_rise) begin
         count_q <= CNT_ZERO;
      end else if (counting) begin
         if (clear_cnt) begin
            count_q <= CNT_ZERO;
         end else begin
            count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // control, compare values and pin history
   always @(posedge CLK) begin
      if (SYS_RST) begin
         timer_control_1_q <= `RST_CTRL;
         compare_a_value_q <= CNT_ZERO;
         period_value_q    <= CNT_ZERO;
         trig_prev_q       <= 1'b0;
         cap0_prev_q       <= 1'b0;
         cap1_prev_q       <= 1'b0;
      end else begin
         trig_prev_q <= EXT_TRIGGER_PIN;
         cap0_prev_q <= CAPTURE_PIN_0;
         cap1_prev_q <= CAPTURE_PIN_1;
         if (wr_ctrl) begin
            timer_control_1_q <= PWDATA[`CTL_W-1:0];
         end
         if (capture) begin
            compare_a_value_q <= count_q;
         end else if (wr_cmpa) begin
            compare_a_value_q <= PWDATA[CNT_W-1:0];
         end
         if (wr_period) begin
            period_value_q <= PWDATA[CNT_W-1:0];
         end
      end
   end

   // flags: write one to clear, a new event wins over the clear
   wire set_a = a_hit || capture;
   wire set_p = p_hit && !(cmp_like && clear_select);
   always @(posedge CLK) begin
      if (SYS_RST) begin
         match_a_flag_q <= 1'b0;
         match_p_flag_q <= 1'b0;
      end else begin
         if (set_a) begin
            match_a_flag_q <= 1'b1;
         end else if (wr_flags && PWDATA[`FLG_A_BIT]) begin
            match_a_flag_q <= 1'b0;
         end
         if (set_p) begin
            match_p_flag_q <= 1'b1;
         end else if (wr_flags && PWDATA[`FLG_P_BIT]) begin
            match_p_flag_q <= 1'b0;
         end
      end
   end

   // internal pwm wave runs whatever the pin action forces
   always @(posedge CLK) begin
      if (SYS_RST) begin
         pwm_wave_q <= 1'b0;
      end else begin
         pwm_wave_q <= run_control_q && (count_q < pwm_duty);
      end
   end

   // output pin
   reg out_d;
   reg cmp_level_q;
   always @(posedge CLK) begin
      if (SYS_RST) begin
         cmp_level_q <= 1'b0;
      end else if (run_rise) begin
         cmp_level_q <= initial_level;
      end else if (a_hit && cmp_like) begin
         case (pin_action_select)
            `IO_0:   cmp_level_q <= cmp_level_q;
            `IO_1:   cmp_level_q <= 1'b0;
            `IO_2:   cmp_level_q <= 1'b1;
            `IO_3:   cmp_level_q <= !cmp_level_q;
            default: cmp_level_q <= cmp_level_q;
         endcase
      end
   end

   always @* begin
      out_d = 1'b0;
      if (single_mode) begin
         // pulse active while run is high; active level is initial_level xor polarity_invert
         out_d = (run_control_q ? initial_level : !initial_level)
                 ^ polarity_invert;
      end else if (pwm_mode) begin
         case (pin_action_select)
            `IO_0:   out_d = 1'b0 ^ polarity_invert;
            `IO_1:   out_d = 1'b1 ^ polarity_invert;
            default: out_d = (pwm_wave_q ? initial_level : !initial_level)
                             ^ polarity_invert;
         endcase
      end else if (mode_select == `MODE_CMP) begin
         out_d = cmp_level_q;
      end else begin
         out_d = 1'b0;
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         TIMER_OUT <= 1'b0;
      end else begin
         TIMER_OUT <= out_d;
      end
   end

   // apb read path and ready, all registered at the setup cycle
   reg [31:0] rdata_d;
   reg        hit_d;
   always @* begin
      rdata_d = 32'h0000_0000;
      hit_d   = 1'b1;
      case (PADDR)
         `OFS_RUN:    rdata_d = {31'h0000_0000, run_control_q};
         `OFS_CTRL:   rdata_d = {24'h00_0000, timer_control_1_q};
         `OFS_COUNT:  rdata_d = {{(32-CNT_W){1'b0}}, count_q};
         `OFS_CMPA:   rdata_d = {{(32-CNT_W){1'b0}}, compare_a_value_q};
         `OFS_PERIOD: rdata_d = {{(32-CNT_W){1'b0}}, period_value_q};
         `OFS_FLAGS:  rdata_d = {30'h0000_0000, match_p_flag_q,
                                 match_a_flag_q};
         default:     hit_d   = 1'b0;
      endcase
   end

   wire setup = PSEL && !PENABLE;
   always @(posedge CLK) begin
      if (SYS_RST) begin
         PRDATA  <= 32'h0000_0000;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= setup;
         PSLVERR <= setup && !hit_d;
         if (setup && !PWRITE) begin
            PRDATA <= rdata_d;
         end else if (!PSEL) begin
            PRDATA <= 32'h0000_0000;
         end
      end
   end

endmodule
`default_nettype wire

// [pkg/tmr_defs.vh]
// constants for the pulse/capture timer block
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH

// register byte offsets
`define OFS_RUN        8'h00
`define OFS_CTRL       8'h04
`define OFS_COUNT      8'h08
`define OFS_CMPA       8'h0C
`define OFS_PERIOD     8'h10
`define OFS_FLAGS      8'h14

// timer_control_1 field positions
`define CTL_CLR_BIT    0
`define CTL_DPX_BIT    1
`define CTL_POL_BIT    2
`define CTL_OC_BIT     3
`define CTL_IO_LO      4
`define CTL_IO_HI      5
`define CTL_M_LO       6
`define CTL_M_HI       7
`define CTL_W          8

// flag positions
`define FLG_A_BIT      0
`define FLG_P_BIT      1

// reset values
`define RST_CTRL       8'h00
`define RST_RUN        1'b0

// mode_select codes
`define MODE_CMP       2'h0
`define MODE_CAP       2'h1
`define MODE_PWM       2'h2
`define MODE_TMR       2'h3

// pin_action_select codes
`define IO_0           2'h0
`define IO_1           2'h1
`define IO_2           2'h2
`define IO_3           2'h3

`endif
